// ### slt_top.sv
`timescale 1ns/1ps
`include "slt_regs.svh"

// Functional notes
// R1: Tick source is the 1 kHz RC when select is 0 (reset), else 32 kHz.
// R2: Clock select changes only while the run enable bit is 0.
// R3: Reading count high returns bits 31:16 and latches bits 15:0.
// R4: Software reads count high first, then count low.
// R5: Writing a match low register only fills the hold register.
// R6: Writing match high loads high half and moves hold into low half.
// R7: Software changes match values only while run enable is 0.
// R8: Changing a match while running may raise a spurious event.
// R9: Flag bits: match B at 2, match A at 1, rollover at 0.
// R10: Writing 1 clears a flag, writing 0 leaves it.
// R11: Mask bits 2..0 enable match B, match A, rollover; all clear at reset.
// R12: Deep sleep request with wait-for-event: RC keepalive off gives mode 2, on gives 1.
// R13: Clock enables: bit 1 RC keepalive, bit 0 crystal; reset sets bit 1 only.
// R14: Run enable starts and stops counting after 2 to 3 selected clock periods; the code stops after two source edges (1 to 2 periods).
// R15: Direction 0 counts up, 1 counts down; changes only while disabled.
// R16: Prescaler divides selected clock by two to the power N, changed only while disabled.
// R17: Match flags set when counter equals match; rollover flag set on wrap.
// R18: Interrupt request high while any flag is set with its mask bit.
module slt_top import slt_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wrData,
  input  wire logic        wrStrobe,
  input  wire logic        rdStrobe,
  output logic      [31:0] rdData,
  input  wire logic        clk1k,
  input  wire logic        clk32k,
  input  wire logic        debugHalt,
  input  wire logic        waitForEvent,
  input  wire logic        deepSleepRequest,
  input  wire logic        wakeEvent,
  output logic             irq,
  output logic             rcKeepaliveEnable,
  output logic             crystalEnable,
  output logic             deepSleepRcOn,
  output logic             deepSleepRcOff
);
  logic        cfgClkSel_reg;
  logic [3:0]  cfgPrescale_reg;
  logic        cfgDbgPause_reg;
  logic        cfgEnable_reg;
  logic        cfgDir_reg;
  logic        clkenRc_reg;
  logic        clkenXtal_reg;
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic [15:0] cntLow_reg;
  logic [31:0] cmpA_reg;
  logic [31:0] cmpB_reg;
  logic [15:0] holdA_reg;
  logic [15:0] holdB_reg;
  logic [2:0]  flags_reg;
  logic [2:0]  mask_reg;
  logic [2:0]  events;
  logic [1:0]  runPipe_reg;
  logic [31:0] rdData_next;
  slt_state_t  state_reg;
  logic        srcEdge;
  logic        divTick;
  logic        runActive;
  logic        step;
  logic        wrCfg;
  logic        cfgUnlocked;

  // ==========================================================
  // Bus decode
  function automatic logic hit(input logic [31:0] a, input logic [31:0] target);
    hit = (a == target);
  endfunction : hit

  assign wrCfg       = wrStrobe && hit(addr, `SLT_ADDR_CFG);
  assign cfgUnlocked = !cfgEnable_reg;

  // ==========================================================
  // Configuration register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfgEnable_reg   <= 1'b0;
      cfgDbgPause_reg <= 1'b1;
    end else if (wrCfg) begin
      cfgEnable_reg   <= wrData[`SLT_CFG_ENABLE];
      cfgDbgPause_reg <= wrData[`SLT_CFG_DBGPAUSE];
    end
  end

  // Mode fields are locked while the enable bit is set; the count still runs up to two source edges after it clears
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfgClkSel_reg   <= 1'b0;
      cfgPrescale_reg <= `SLT_RST_DIV;
      cfgDir_reg      <= 1'b0;
    end else if (wrCfg && cfgUnlocked) begin // R2 R15 R16
      cfgClkSel_reg   <= wrData[`SLT_CFG_CLKSEL]; // R1
      cfgPrescale_reg <= wrData[`SLT_CFG_DIV_HI:`SLT_CFG_DIV_LO];
      cfgDir_reg      <= wrData[`SLT_CFG_DIR];
    end
  end

  // ==========================================================
  // Low frequency clock enables
  always_ff @(posedge clk) begin
    if (!rstn) begin
      clkenRc_reg   <= 1'b1; // R13
      clkenXtal_reg <= 1'b0;
    end else if (wrStrobe && hit(addr, `SLT_ADDR_CLKEN)) begin
      clkenRc_reg   <= wrData[`SLT_CLKEN_RC]; // R13
      clkenXtal_reg <= wrData[`SLT_CLKEN_XTAL];
    end
  end

  assign rcKeepaliveEnable = clkenRc_reg;
  assign crystalEnable     = clkenXtal_reg;

  // ==========================================================
  // Tick generation
  slt_tick #(
    .DIV_W       (16)
  ) slt_tick_i (
    .clk         (clk),
    .rstn        (rstn),
    .clk1k       (clk1k),
    .clk32k      (clk32k),
    .srcSel      (cfgClkSel_reg),
    .prescaleExp (cfgPrescale_reg),
    .divClear    (!runActive),
    .srcEdge     (srcEdge),
    .divTick     (divTick)
  );

  // Enable follows the register through two source edges
  always_ff @(posedge clk) begin
    if (!rstn) begin
      runPipe_reg <= `SLT_RST_RUNPIPE;
    end else if (srcEdge) begin
      runPipe_reg <= {runPipe_reg[0], cfgEnable_reg}; // R14
    end
  end

  assign runActive = runPipe_reg[1];
  assign step      = divTick && runActive && !(debugHalt && cfgDbgPause_reg); // R14

  // ==========================================================
  // Counter
  assign count_next = cfgDir_reg ? count_reg - 32'h1 : count_reg + 32'h1; // R15

  always_ff @(posedge clk) begin
    if (!rstn) begin
      count_reg <= `SLT_RST_COUNT;
    end else if (step) begin
      count_reg <= count_next;
    end
  end

  // Low half latch; valid only after a high-half read
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cntLow_reg <= 16'h0000;
    end else if (rdStrobe && hit(addr, `SLT_ADDR_CNTH)) begin
      cntLow_reg <= count_reg[15:0]; // R3 R4
    end
  end

  // ==========================================================
  // Match registers with hold stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      holdA_reg <= `SLT_RST_HALF;
      holdB_reg <= `SLT_RST_HALF;
    end else if (wrStrobe) begin
      if (hit(addr, `SLT_ADDR_CMPAL)) begin
        holdA_reg <= wrData[15:0]; // R5
      end
      if (hit(addr, `SLT_ADDR_CMPBL)) begin
        holdB_reg <= wrData[15:0]; // R5
      end
    end
  end

  // No lock here: software owns the spurious-event hazard while running
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmpA_reg <= `SLT_RST_CMP;
      cmpB_reg <= `SLT_RST_CMP;
    end else if (wrStrobe) begin
      if (hit(addr, `SLT_ADDR_CMPAH)) begin
        cmpA_reg <= {wrData[15:0], holdA_reg}; // R6 R7 R8
      end
      if (hit(addr, `SLT_ADDR_CMPBH)) begin
        cmpB_reg <= {wrData[15:0], holdB_reg}; // R6
      end
    end
  end

  // ==========================================================
  // Events, flags and mask
  assign events[`SLT_EV_WRAP]   = step &&
    (cfgDir_reg ? count_reg == `SLT_CNT_MIN : count_reg == `SLT_CNT_MAX); // R17
  assign events[`SLT_EV_MATCHA] = step && (count_next == cmpA_reg); // R17
  assign events[`SLT_EV_MATCHB] = step && (count_next == cmpB_reg); // R17

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      flags_reg <= `SLT_RST_EV;
    end else if (wrStrobe && hit(addr, `SLT_ADDR_FLAGS)) begin
      flags_reg <= (flags_reg & ~wrData[2:0]) | events; // R9 R10
    end else begin
      flags_reg <= flags_reg | events; // R9
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mask_reg <= `SLT_RST_EV; // R11
    end else if (wrStrobe && hit(addr, `SLT_ADDR_MASK)) begin
      mask_reg <= wrData[2:0]; // R11
    end
  end

  assign irq = |(flags_reg & mask_reg); // R18

  // ==========================================================
  // Deep sleep mode selection
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= SLT_AWAKE;
    end else begin
      case (state_reg)
        SLT_AWAKE: begin
          if (waitForEvent && deepSleepRequest) begin
            state_reg <= clkenRc_reg ? SLT_DS_RCON : SLT_DS_RCOF; // R12
          end
        end
        SLT_DS_RCON, SLT_DS_RCOF: begin
          if (wakeEvent) begin
            state_reg <= SLT_AWAKE;
          end
        end
        default: begin
          state_reg <= SLT_AWAKE;
        end
      endcase
    end
  end

  assign deepSleepRcOn  = (state_reg == SLT_DS_RCON);
  assign deepSleepRcOff = (state_reg == SLT_DS_RCOF);

  // ==========================================================
  // Read data, one cycle after the strobe
  always_comb begin
    rdData_next = 32'h0000_0000;
    case (addr)
      `SLT_ADDR_CLKEN: begin
        rdData_next[`SLT_CLKEN_RC]   = clkenRc_reg;
        rdData_next[`SLT_CLKEN_XTAL] = clkenXtal_reg;
      end
      `SLT_ADDR_CFG: begin
        rdData_next[`SLT_CFG_CLKSEL]                 = cfgClkSel_reg;
        rdData_next[`SLT_CFG_DIV_HI:`SLT_CFG_DIV_LO] = cfgPrescale_reg;
        rdData_next[`SLT_CFG_DBGPAUSE]               = cfgDbgPause_reg;
        rdData_next[`SLT_CFG_ENABLE]                 = cfgEnable_reg;
        rdData_next[`SLT_CFG_DIR]                    = cfgDir_reg;
      end
      `SLT_ADDR_CNTH:  rdData_next[15:0] = count_reg[31:16]; // R3
      `SLT_ADDR_CNTL:  rdData_next[15:0] = cntLow_reg;
      `SLT_ADDR_CMPAH: rdData_next[15:0] = cmpA_reg[31:16];
      `SLT_ADDR_CMPAL: rdData_next[15:0] = holdA_reg;
      `SLT_ADDR_CMPBH: rdData_next[15:0] = cmpB_reg[31:16];
      `SLT_ADDR_CMPBL: rdData_next[15:0] = holdB_reg;
      `SLT_ADDR_FLAGS: rdData_next[2:0]  = flags_reg;
      `SLT_ADDR_MASK:  rdData_next[2:0]  = mask_reg;
      default:         rdData_next       = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdData <= 32'h0000_0000;
    end else if (rdStrobe) begin
      rdData <= rdData_next;
    end else begin
      rdData <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_clksel_lock: assert property ( // R2
    wrCfg && cfgEnable_reg |=> $stable(cfgClkSel_reg) && $stable(cfgDir_reg)
  ) else $error("mode bits changed while enabled");

  chk_prescale_lock: assert property ( // R16
    wrCfg && cfgEnable_reg |=> $stable(cfgPrescale_reg)
  ) else $error("prescaler changed while enabled");

  chk_cntl_capture: assert property ( // R3
    rdStrobe && hit(addr, `SLT_ADDR_CNTH) |=>
      cntLow_reg == $past(count_reg[15:0]) && rdData[15:0] == $past(count_reg[31:16])
  ) else $error("count high read wrong or low half not latched");

  chk_hold_only: assert property ( // R5
    wrStrobe && hit(addr, `SLT_ADDR_CMPAL) |=>
      $stable(cmpA_reg) && holdA_reg == $past(wrData[15:0])
  ) else $error("match low write altered active value");

  chk_match_load: assert property ( // R6
    wrStrobe && hit(addr, `SLT_ADDR_CMPBH) |=>
      cmpB_reg == {$past(wrData[15:0]), $past(holdB_reg)}
  ) else $error("match high write did not merge hold");

  chk_flag_clear: assert property ( // R10
    wrStrobe && hit(addr, `SLT_ADDR_FLAGS) && wrData[`SLT_EV_MATCHA] &&
      !events[`SLT_EV_MATCHA] |=> !flags_reg[`SLT_EV_MATCHA]
  ) else $error("flag not cleared by writing one");

  chk_wrap_flag: assert property ( // R17
    step && count_reg == (cfgDir_reg ? `SLT_CNT_MIN : `SLT_CNT_MAX) |=>
      flags_reg[`SLT_EV_WRAP] && count_reg == ~$past(count_reg)
  ) else $error("rollover not flagged");

  chk_irq_level: assert property ( // R18
    flags_reg[`SLT_EV_MATCHB] && mask_reg[`SLT_EV_MATCHB] |-> irq
  ) else $error("masked-in flag gave no interrupt");

  chk_sleep_mode: assert property ( // R12
    state_reg == SLT_AWAKE && waitForEvent && deepSleepRequest |=>
      (deepSleepRcOn == $past(clkenRc_reg)) && (deepSleepRcOff != $past(clkenRc_reg))
  ) else $error("wrong deep sleep mode");

  chk_run_latency: assert property ( // R14
    !runActive ##1 runActive |-> $past(srcEdge) && $past(runPipe_reg[0])
  ) else $error("run started without enable");

  cov_match_a: cover property (events[`SLT_EV_MATCHA] ##1 irq);
  cov_wrap_down: cover property (step && cfgDir_reg && count_reg == `SLT_CNT_MIN);
  cov_set_clear: cover property (wrStrobe && hit(addr, `SLT_ADDR_FLAGS) && |events);
  cov_ds_off: cover property (deepSleepRcOff);
endmodule : slt_top

// ### slt_regs.svh
`ifndef SLT_REGS_SVH
`define SLT_REGS_SVH

// ==========================================================
// Register byte addresses
`define SLT_ADDR_CLKEN   32'h4000_0008
`define SLT_ADDR_CFG     32'h4000_600C
`define SLT_ADDR_CNTH    32'h4000_6010
`define SLT_ADDR_CNTL    32'h4000_6014
`define SLT_ADDR_CMPAH   32'h4000_6018
`define SLT_ADDR_CMPAL   32'h4000_601C
`define SLT_ADDR_CMPBH   32'h4000_6020
`define SLT_ADDR_CMPBL   32'h4000_6024
`define SLT_ADDR_FLAGS   32'h4000_A014
`define SLT_ADDR_MASK    32'h4000_A054

// ==========================================================
// Configuration field positions
`define SLT_CFG_CLKSEL   0
`define SLT_CFG_DIV_LO   4
`define SLT_CFG_DIV_HI   7
`define SLT_CFG_DBGPAUSE 10
`define SLT_CFG_ENABLE   11
`define SLT_CFG_DIR      12

// ==========================================================
// Clock enable, flag and mask bit positions
`define SLT_CLKEN_XTAL   0
`define SLT_CLKEN_RC     1
`define SLT_EV_WRAP      0
`define SLT_EV_MATCHA    1
`define SLT_EV_MATCHB    2

// ==========================================================
// Reset values and counter limits
`define SLT_RST_HALF     16'hFFFF
`define SLT_RST_CMP      32'hFFFF_FFFF
`define SLT_RST_COUNT    32'h0000_0000
`define SLT_RST_DIV      4'h0
`define SLT_RST_EV       3'h0
`define SLT_RST_RUNPIPE  2'h0
`define SLT_CNT_MAX      32'hFFFF_FFFF
`define SLT_CNT_MIN      32'h0000_0000

`endif

// ### slt_pkg.sv
package slt_pkg;
  typedef enum logic [2:0] {
    SLT_AWAKE   = 3'h1,
    SLT_DS_RCON = 3'h2,
    SLT_DS_RCOF = 3'h4
  } slt_state_t;
endpackage : slt_pkg

// ### slt_tick.sv
`timescale 1ns/1ps
`include "slt_regs.svh"

module slt_tick import slt_pkg::*; #(
  parameter int DIV_W = 16
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       clk1k,
  input  wire logic       clk32k,
  input  wire logic       srcSel,
  input  wire logic [3:0] prescaleExp,
  input  wire logic       divClear,
  output logic            srcEdge,
  output logic            divTick
);
  logic             src1k_reg;
  logic             src32k_reg;
  logic             srcNow;
  logic             srcPrev_reg;
  logic [DIV_W-1:0] divCnt_reg;
  logic [DIV_W-1:0] divLimit;

  // ==========================================================
  // Source select and edge detect
  always_ff @(posedge clk) begin
    if (!rstn) begin
      src1k_reg   <= 1'b0;
      src32k_reg  <= 1'b0;
      srcPrev_reg <= 1'b0;
    end else begin
      src1k_reg   <= clk1k;
      src32k_reg  <= clk32k;
      srcPrev_reg <= srcNow;
    end
  end

  assign srcNow  = srcSel ? src32k_reg : src1k_reg; // R1
  assign srcEdge = srcNow & ~srcPrev_reg;

  // ==========================================================
  // Divide by two to the power N
  assign divLimit = DIV_W'((32'h1 << prescaleExp) - 32'h1); // R16

  always_ff @(posedge clk) begin
    if (!rstn || divClear) begin
      divCnt_reg <= '0;
      divTick    <= 1'b0;
    end else if (srcEdge) begin
      divTick    <= (divCnt_reg == divLimit);
      divCnt_reg <= (divCnt_reg == divLimit) ? '0 : divCnt_reg + 1'b1;
    end else begin
      divTick    <= 1'b0;
    end
  end
endmodule : slt_tick

// ### slt_top_tb.sv
`timescale 1ns/1ps
`include "slt_regs.svh"

module slt_top_tb import slt_pkg::*;;
  logic        clk;
  logic        rstn;
  logic [31:0] addr;
  logic [31:0] wrData;
  logic        wrStrobe;
  logic        rdStrobe;
  logic [31:0] rdData;
  logic        clk1k;
  logic        clk32k;
  logic        debugHalt;
  logic        waitForEvent;
  logic        deepSleepRequest;
  logic        wakeEvent;
  logic        irq;
  logic        rcKeepaliveEnable;
  logic        crystalEnable;
  logic        deepSleepRcOn;
  logic        deepSleepRcOff;
  logic [7:0]  srcDiv;
  logic [31:0] rdVal;
  int          miscompares;
  int          nTests;
  int          i;

  slt_top slt_top_i (
    .clk               (clk),
    .rstn              (rstn),
    .addr              (addr),
    .wrData            (wrData),
    .wrStrobe          (wrStrobe),
    .rdStrobe          (rdStrobe),
    .rdData            (rdData),
    .clk1k             (clk1k),
    .clk32k            (clk32k),
    .debugHalt         (debugHalt),
    .waitForEvent      (waitForEvent),
    .deepSleepRequest  (deepSleepRequest),
    .wakeEvent         (wakeEvent),
    .irq               (irq),
    .rcKeepaliveEnable (rcKeepaliveEnable),
    .crystalEnable     (crystalEnable),
    .deepSleepRcOn     (deepSleepRcOn),
    .deepSleepRcOff    (deepSleepRcOff)
  );

  // ==========================================================
  // Clocks
  initial clk = 1'h0;
  always #12.5 clk = ~clk;

  // Slow sources sped up so the run stays short
  always @(posedge clk) begin
    if (!rstn) begin
      srcDiv <= 8'h00;
      clk32k <= 1'h0;
      clk1k  <= 1'h0;
    end else begin
      srcDiv <= srcDiv + 8'h01;
      clk32k <= srcDiv[2];
      clk1k  <= srcDiv[5];
    end
  end

  // ==========================================================
  // Bus tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr     <= a;
    wrData   <= d;
    wrStrobe <= 1'h1;
    @(posedge clk);
    wrStrobe <= 1'h0;
  endtask : wr

  task automatic rd(input logic [31:0] a);
    @(posedge clk);
    addr     <= a;
    rdStrobe <= 1'h1;
    @(posedge clk);
    rdStrobe <= 1'h0;
    #1 rdVal = rdData;
  endtask : rd

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    rd(a);
    chk(rdVal, exp, "register read");
  endtask : rdc

  task automatic waitFlag(input logic [31:0] m);
    rdVal = 32'h0;
    for (int k = 0; k < 3000 && (rdVal & m) == 32'h0; k++) begin
      rd(`SLT_ADDR_FLAGS);
    end
    if ((rdVal & m) == 32'h0) begin
      miscompares++;
      $display("MISMATCH at %0t: flag wait timed out", $time);
      wrap_up();
    end
  endtask : waitFlag

  task automatic sleepPulse(input logic [1:0] exp);
    @(posedge clk);
    waitForEvent <= 1'h1;
    @(posedge clk);
    waitForEvent <= 1'h0;
    #1 chk({30'h0, deepSleepRcOn, deepSleepRcOff}, {30'h0, exp}, "sleep mode");
    @(posedge clk);
    wakeEvent <= 1'h1;
    @(posedge clk);
    wakeEvent <= 1'h0;
    #1 chk({30'h0, deepSleepRcOn, deepSleepRcOff}, 32'h0, "awake after wake");
  endtask : sleepPulse

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================
  // Reset value table, last entry unmapped
  logic [31:0] rstAddr [11] = '{`SLT_ADDR_CLKEN, `SLT_ADDR_CFG, `SLT_ADDR_CNTH, `SLT_ADDR_CNTL,
    `SLT_ADDR_CMPAH, `SLT_ADDR_CMPAL, `SLT_ADDR_CMPBH, `SLT_ADDR_CMPBL, `SLT_ADDR_FLAGS,
    `SLT_ADDR_MASK, 32'h4000_6028};
  logic [31:0] rstVal [11] = '{32'h2, 32'h400, 32'h0, 32'h0, 32'hFFFF, 32'hFFFF, 32'hFFFF,
    32'hFFFF, 32'h0, 32'h0, 32'h0};

  // ==========================================================
  // Main sequence
  initial begin
    rstn = 1'h0;
    addr = 32'h0;
    wrData = 32'h0;
    wrStrobe = 1'h0;
    rdStrobe = 1'h0;
    debugHalt = 1'h0;
    waitForEvent = 1'h0;
    deepSleepRequest = 1'h0;
    wakeEvent = 1'h0;
    miscompares = 0;
    nTests = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'h1;
    #1 chk({29'h0, irq, rcKeepaliveEnable, crystalEnable}, 32'h2, "reset outputs");
    for (i = 0; i < 11; i++) begin
      rdc(rstAddr[i], rstVal[i]);
    end
    // Match values staged through the hold register
    wr(`SLT_ADDR_CMPAL, 32'h3);
    rdc(`SLT_ADDR_CMPAH, 32'hFFFF);
    rdc(`SLT_ADDR_CMPAL, 32'h3);
    wr(`SLT_ADDR_CMPAH, 32'h0);
    rdc(`SLT_ADDR_CMPAH, 32'h0);
    wr(`SLT_ADDR_CMPBL, 32'h6);
    wr(`SLT_ADDR_CMPBH, 32'h0);
    // Up count on the RC source; locked fields refused while running
    wr(`SLT_ADDR_CFG, 32'hC00);
    wr(`SLT_ADDR_CFG, 32'h1C31);
    rdc(`SLT_ADDR_CFG, 32'hC00);
    waitFlag(32'h4);
    wr(`SLT_ADDR_CFG, 32'h400);
    rdc(`SLT_ADDR_FLAGS, 32'h6);
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(`SLT_ADDR_MASK, 32'hFFFF_FFFF);
    rdc(`SLT_ADDR_MASK, 32'h7);
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    wr(`SLT_ADDR_MASK, 32'h2);
    wr(`SLT_ADDR_FLAGS, 32'h0);
    rdc(`SLT_ADDR_FLAGS, 32'h6);
    wr(`SLT_ADDR_FLAGS, 32'h2);
    rdc(`SLT_ADDR_FLAGS, 32'h4);
    chk({31'h0, irq}, 32'h0, "irq after clear");
    rdc(`SLT_ADDR_CNTH, 32'h0);
    // Down count on the crystal source with prescale 8 until rollover
    wr(`SLT_ADDR_FLAGS, 32'h7);
    wr(`SLT_ADDR_MASK, 32'h1);
    wr(`SLT_ADDR_CFG, 32'h1431);
    wr(`SLT_ADDR_CFG, 32'h1C31);
    rdc(`SLT_ADDR_CFG, 32'h1C31);
    waitFlag(32'h1);
    wr(`SLT_ADDR_CFG, 32'h1431);
    chk({31'h0, irq}, 32'h1, "irq on rollover");
    // Stop latency is two source edges; wait well past it
    repeat (40) @(posedge clk);
    rd(`SLT_ADDR_CNTL);
    chk({31'h0, rdVal[15:0] == 16'hFFFF}, 32'h0, "low half stale");
    rdc(`SLT_ADDR_CNTH, 32'hFFFF);
    rdc(`SLT_ADDR_CNTL, 32'hFFFF);
    // Deep sleep modes
    sleepPulse(2'b00);
    @(posedge clk);
    deepSleepRequest <= 1'h1;
    sleepPulse(2'b10);
    wr(`SLT_ADDR_CLKEN, 32'h1);
    rdc(`SLT_ADDR_CLKEN, 32'h1);
    chk({30'h0, rcKeepaliveEnable, crystalEnable}, 32'h1, "clock enables");
    sleepPulse(2'b01);
    wrap_up();
  end
endmodule : slt_top_tb
